//--- rtl/nand_timing_pkg.sv
// constants and types for the multi-level nand strobe timing block
package nand_timing_pkg;

  // byte addresses of the register words
  localparam logic [7:0] TIMING_ADDR = 8'h00;
  localparam logic [7:0] CMD_ADDR = 8'h04;
  localparam logic [7:0] STATUS_ADDR = 8'h08;

  // timing register reset: slowest strobes
  localparam logic [31:0] TIMING_RST = 32'h03FF_FFFF;
  // writable bits of the timing register, rest read zero
  localparam logic [31:0] TIMING_WMASK = 32'h03FF_FFFF;

  // command register bits
  localparam int CMD_READ_BIT = 0;
  localparam int CMD_WRITE_BIT = 1;

  // status register bits
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_RB_LOW_BIT = 1;
  localparam int ST_RELEASED_BIT = 2;
  localparam int ST_SAMPLING_BIT = 3;
  localparam int ST_RB_LEVEL_BIT = 4;

  // ahb transfer type codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;

  // counter width, covers 31 busy delay and 15 + 7 release
  localparam int CNT_W = 6;

  // field layout of the timing register
  typedef struct packed {
    logic [5:0] rsvd;
    logic [1:0] ce_to_re; // chip_enable_to_read_delay
    logic [4:0] busy_dly;
    logic [2:0] turnaround; // bus_turnaround_count
    logic [3:0] rd_high;
    logic [3:0] rd_low;
    logic [3:0] wr_high;
    logic [3:0] wr_low;
  } flash_timing_t;

  // strobes toward the flash, all active low
  typedef struct packed {
    logic ce_n;
    logic re_n;
    logic we_n;
  } flash_strobe_t;

  // sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_LEAD,
    ST_STROBE,
    ST_TAIL
  } seq_state_t;

endpackage

//--- rtl/multilevel_nand_strobe_timing.sv
// strobe timing generator with ahb-lite register access
`timescale 1ns/10ps
module multilevel_nand_strobe_timing
  import nand_timing_pkg::*;
(
  // clock, reset, enable
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic ce_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic hready_i,
  input wire logic [31:0] hwdata_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // flash pins
  input wire logic rb_n_i,
  output flash_strobe_t strobe_o,
  output logic bus_released_o,
  output logic rb_sample_o
);

  // register file and snapshot
  flash_timing_t timing_r; // software timing word
  flash_timing_t snap_r; // copy used by the running cycle
  logic [31:0] hrdata_r; // registered read data
  logic rb_low_seen_r; // sticky: ready/busy seen low
  logic is_read_r; // running cycle is a read
  // ahb data phase bookkeeping
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  // ready/busy synchroniser
  logic rb_meta_r;
  logic rb_sync_r;
  // sequencer
  seq_state_t st_r;
  logic [CNT_W-1:0] cnt_r;
  // decoded timing of the running cycle
  logic [3:0] lo_s;
  logic [3:0] hi_s;
  logic [3:0] hg_s; // clamped high minus low
  logic [CNT_W-1:0] rel_end_s;
  logic [CNT_W-1:0] busy_s;
  logic [CNT_W-1:0] tail_end_s;
  // bus decode
  logic addr_ok_s;
  logic start_rd_s;
  logic start_wr_s;
  logic [31:0] status_s;

  // never stall except when frozen, always okay
  assign hreadyout_o = ce_i;
  assign hresp_o = 1'b0;
  assign hrdata_o = hrdata_r;
  assign addr_ok_s = hsel_i && hready_i && ce_i &&
                     (htrans_i == HTRANS_NONSEQ || htrans_i == HTRANS_SEQ);

  // command write starts a cycle only when idle
  assign start_rd_s = wr_pend_r && wr_addr_r == CMD_ADDR &&
                      hwdata_i[CMD_READ_BIT] && st_r == ST_IDLE;
  assign start_wr_s = wr_pend_r && wr_addr_r == CMD_ADDR &&
                      !hwdata_i[CMD_READ_BIT] &&
                      hwdata_i[CMD_WRITE_BIT] && st_r == ST_IDLE;

  // status word seen by software
  always_comb begin
    status_s = 32'h0000_0000;
    status_s[ST_BUSY_BIT] = st_r != ST_IDLE;
    status_s[ST_RB_LOW_BIT] = rb_low_seen_r;
    status_s[ST_RELEASED_BIT] = bus_released_o;
    status_s[ST_SAMPLING_BIT] = rb_sample_o;
    status_s[ST_RB_LEVEL_BIT] = rb_sync_r;
  end

  // address phase capture and read data
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata_r <= 32'h0000_0000;
    end else if (ce_i) begin
      wr_pend_r <= addr_ok_s && hwrite_i;
      wr_addr_r <= haddr_i[7:0];
      if (addr_ok_s && !hwrite_i) begin
        // unmapped words read as zero
        case (haddr_i[7:0])
          TIMING_ADDR: hrdata_r <= timing_r;
          STATUS_ADDR: hrdata_r <= status_s;
          default: hrdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  // timing register write, upper bits stay zero
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      timing_r <= TIMING_RST;
    end else if (ce_i && wr_pend_r && wr_addr_r == TIMING_ADDR) begin
      timing_r <= hwdata_i & TIMING_WMASK;
    end
  end

  // two flops on the ready/busy pin
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rb_meta_r <= 1'b1;
      rb_sync_r <= 1'b1;
    end else if (ce_i) begin
      rb_meta_r <= rb_n_i;
      rb_sync_r <= rb_meta_r;
    end
  end

  // decode the snapshot; high below low is taken as equal
  assign lo_s = is_read_r ? snap_r.rd_low : snap_r.wr_low;
  assign hi_s = is_read_r ? snap_r.rd_high : snap_r.wr_high;
  assign hg_s = (hi_s >= lo_s) ? hi_s - lo_s : 4'h0;
  assign rel_end_s = {2'b00, hg_s} +
                     (is_read_r ? {3'b000, snap_r.turnaround} : 6'h00);
  assign busy_s = {1'b0, snap_r.busy_dly};
  assign tail_end_s = (rel_end_s > busy_s) ? rel_end_s : busy_s;

  // snapshot taken at start, cycle never sees later writes
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      snap_r <= TIMING_RST;
      is_read_r <= 1'b0;
    end else if (ce_i && (start_rd_s || start_wr_s)) begin
      snap_r <= timing_r;
      is_read_r <= start_rd_s;
    end
  end

  // strobe sequencer
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      st_r <= ST_IDLE;
      cnt_r <= '0;
    end else if (ce_i) begin
      case (st_r)
        ST_IDLE: begin
          cnt_r <= '0;
          // reads wait the lead count first
          if (start_rd_s && timing_r.ce_to_re != 2'h0) begin
            st_r <= ST_LEAD;
          end else if (start_rd_s || start_wr_s) begin
            st_r <= ST_STROBE;
          end
        end
        ST_LEAD: begin
          // chip enable low, read enable still high
          if (cnt_r == {4'h0, snap_r.ce_to_re} - 6'h01) begin
            st_r <= ST_STROBE;
            cnt_r <= '0;
          end else begin
            cnt_r <= cnt_r + 6'h01;
          end
        end
        ST_STROBE: begin
          // strobe low for low field plus one
          if (cnt_r == {2'b00, lo_s}) begin
            st_r <= ST_TAIL;
            cnt_r <= '0;
          end else begin
            cnt_r <= cnt_r + 6'h01;
          end
        end
        ST_TAIL: begin
          // high phase, then release and busy wait
          if (cnt_r >= tail_end_s) begin
            st_r <= ST_IDLE;
            cnt_r <= '0;
          end else begin
            cnt_r <= cnt_r + 6'h01;
          end
        end
        default: begin
          st_r <= ST_IDLE;
          cnt_r <= '0;
        end
      endcase
    end
  end

  // strobe pins decoded from the state flops
  assign strobe_o.ce_n = st_r == ST_IDLE;
  assign strobe_o.re_n = !(st_r == ST_STROBE && is_read_r);
  assign strobe_o.we_n = !(st_r == ST_STROBE && !is_read_r);
  // on reads the flash owns the bus until the release count
  assign bus_released_o = !(is_read_r && (st_r == ST_STROBE ||
                          (st_r == ST_TAIL && cnt_r < rel_end_s)));
  // sampling only after the busy delay
  assign rb_sample_o = st_r == ST_TAIL && cnt_r >= busy_s;

  // sticky busy flag, set wins over the clear at start
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rb_low_seen_r <= 1'b0;
    end else if (ce_i) begin
      if (rb_sample_o && !rb_sync_r) begin
        rb_low_seen_r <= 1'b1;
      end else if (start_rd_s || start_wr_s) begin
        rb_low_seen_r <= 1'b0;
      end
    end
  end

  // helper counters for the checks below
  logic [CNT_W-1:0] lead_len_r; // ce low before strobe
  logic [CNT_W-1:0] low_len_r; // strobe low cycles
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      lead_len_r <= '0;
      low_len_r <= '0;
    end else if (ce_i) begin
      lead_len_r <= (st_r == ST_LEAD) ? lead_len_r + 6'h01 :
                    (st_r == ST_IDLE) ? 6'h00 : lead_len_r;
      low_len_r <= (st_r == ST_STROBE) ? low_len_r + 6'h01 : 6'h00;
    end
  end

  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);

  // with no lead count chip enable falls together with read enable
  lead_count_a:
    assert property ($fell(strobe_o.re_n) |->
                     lead_len_r == {4'h0, snap_r.ce_to_re} &&
                     (snap_r.ce_to_re == 2'h0 ? $fell(strobe_o.ce_n)
                                              : !$past(strobe_o.ce_n)))
    else $error("chip enable to read enable lead wrong");

  we_low_len_a:
    assert property ($rose(strobe_o.we_n) |->
                     low_len_r == {2'b00, snap_r.wr_low} + 6'h01)
    else $error("write pulse width wrong");

  // the cycle may not end before the high count has run
  we_high_hold_a:
    assert property (st_r == ST_TAIL && !is_read_r && cnt_r < {2'b00, hg_s}
                     |=> st_r == ST_TAIL && strobe_o.we_n &&
                         !strobe_o.ce_n)
    else $error("write high time cut short");

  re_low_len_a:
    assert property ($rose(strobe_o.re_n) |->
                     low_len_r == {2'b00, snap_r.rd_low} + 6'h01)
    else $error("read pulse width wrong");

  // same for the read high phase
  re_high_hold_a:
    assert property (st_r == ST_TAIL && is_read_r && cnt_r < {2'b00, hg_s}
                     |=> st_r == ST_TAIL && strobe_o.re_n &&
                         !strobe_o.ce_n)
    else $error("read high time cut short");

  bus_release_a:
    assert property (st_r == ST_TAIL && is_read_r |->
                     bus_released_o == (cnt_r >= rel_end_s))
    else $error("bus release at wrong count");

  rb_sample_read_a:
    assert property ($rose(strobe_o.re_n) && snap_r.busy_dly != 5'h00
                     |-> !rb_sample_o)
    else $error("ready sampled too soon after read");

  // write tail opens with sampling off unless the delay is zero
  rb_sample_wr_a:
    assert property ($rose(strobe_o.we_n) |->
                     rb_sample_o == (snap_r.busy_dly == 5'h00))
    else $error("ready sampled too soon after write");

  snap_stable_a:
    assert property (st_r != ST_IDLE && $past(st_r) != ST_IDLE
                     |-> $stable(snap_r))
    else $error("timing changed inside a cycle");

  // enable low must freeze sequencer and timing outright
  freeze_hold_a:
    assert property (!ce_i |=> $stable(st_r) && $stable(cnt_r) &&
                     $stable(timing_r))
    else $error("state moved while enable low");

  // flash still owns the bus as read enable rises unless the release count is zero
  rd_bus_held_a:
    assert property ($rose(strobe_o.re_n) &&
                     ({2'b00, hg_s} + {3'b000, snap_r.turnaround}) != 6'h00
                     |-> !bus_released_o)
    else $error("bus released as read enable rose");

  // ready/busy is only looked at inside the tail
  rb_in_cycle_a:
    assert property (rb_sample_o |-> !strobe_o.ce_n && strobe_o.re_n &&
                     strobe_o.we_n)
    else $error("ready sampled outside the tail");

  // a low level seen while sampling must stick
  rb_sticky_a:
    assert property (rb_sample_o && !rb_sync_r && ce_i |=> rb_low_seen_r)
    else $error("busy level seen but not kept");

endmodule

//--- verif/flash_model.sv
// behavioural nand flash answering busy after each strobe rise while busy_en_i is set
`timescale 1ns/10ps
module flash_model
  import nand_timing_pkg::*;
(
  // clock and controls
  input wire logic clock_i,
  input wire logic busy_en_i,
  // flash pins
  input wire flash_strobe_t strobe_i,
  output logic rb_n_o
);
  logic prev_r = 1'b1; // both strobes high one cycle ago
  logic [5:0] busy_r = 6'h00; // busy cycles left
  // accepts any programmed interval
  // goes busy on a strobe rise; long enough to span the sample window
  always_ff @(posedge clock_i) begin
    prev_r <= strobe_i.re_n & strobe_i.we_n;
    if (busy_en_i && !prev_r && (strobe_i.re_n & strobe_i.we_n)) begin
      busy_r <= 6'h28;
    end else if (busy_r != 6'h00) begin
      busy_r <= busy_r - 6'h01;
    end
  end
  assign rb_n_o = (busy_r == 6'h00);
endmodule

//--- verif/multilevel_nand_strobe_timing_tb.sv
// self-checking bench for the nand strobe timing block
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin samples_checked++; if ((ex) !== (gt)) begin \
  n_mismatch++; $display("BAD %s exp %0h got %0h", nm, ex, gt); end end
module multilevel_nand_strobe_timing_tb;
  import nand_timing_pkg::*;
  logic clock_i = 1'b0, srst_i = 1'b1, ce_i = 1'b1, busy_en = 1'b0;
  logic hsel_i = 1'b0, hwrite_i = 1'b0;
  logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o, q, nt;
  logic [1:0] htrans_i = 2'h0;
  logic [2:0] hsize_i = 3'h2;
  logic hreadyout_o, hresp_o, rb_n_i, bus_released_o, rb_sample_o;
  flash_strobe_t strobe_o;
  flash_timing_t tm; // timing the current cycle runs with
  int n_mismatch = 0, samples_checked = 0;
  always #2.5 clock_i = ~clock_i;
  multilevel_nand_strobe_timing uut (.clock_i(clock_i), .srst_i(srst_i),
    .ce_i(ce_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
    .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hready_i(hreadyout_o),
    .hwdata_i(hwdata_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .rb_n_i(rb_n_i), .strobe_o(strobe_o),
    .bus_released_o(bus_released_o), .rb_sample_o(rb_sample_o));
  flash_model flash (.clock_i(clock_i), .busy_en_i(busy_en),
    .strobe_i(strobe_o), .rb_n_o(rb_n_i));
  // high time after the pulse, zero when high is below low
  function automatic int hi_x(input logic [3:0] h, input logic [3:0] l);
    return (h > l) ? h - l : 0;
  endfunction
  // last tail count: longer of release and busy wait
  function automatic int tail_t(input flash_timing_t t, input logic rd);
    int hh;
    hh = rd ? hi_x(t.rd_high, t.rd_low) + t.turnaround
            : hi_x(t.wr_high, t.wr_low);
    return (hh > t.busy_dly) ? hh : t.busy_dly;
  endfunction
  // one ahb-lite single word transfer, q takes read data
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel_i <= 1'b1;
    haddr_i <= {24'h0, a};
    htrans_i <= HTRANS_NONSEQ;
    hwrite_i <= w;
    do @(posedge clock_i); while (hreadyout_o !== 1'b1);
    htrans_i <= 2'h0;
    hsel_i <= 1'b0;
    hwdata_i <= d;
    do @(posedge clock_i); while (hreadyout_o !== 1'b1);
    q = hrdata_o;
    `CHK("hresp", 1'b0, hresp_o)
  endtask
  // start a cycle, count its phases, optionally retime mid-cycle
  task flash_cycle(input logic rd, input logic mid, input logic [31:0] t);
    int lead, low, tail, rel0, nsamp;
    logic seen;
    lead = 0;
    low = 0;
    tail = 0;
    rel0 = 0;
    nsamp = 0;
    seen = 1'b0;
    bus(1'b1, CMD_ADDR, rd ? 32'h1 : 32'h2);
    fork
      for (int i = 0; i < 200; i++) begin
        #1;
        if (strobe_o.ce_n !== 1'b0) break;
        if ((strobe_o.re_n & strobe_o.we_n) === 1'b0) begin
          low++;
          seen = 1'b1;
        end else if (!seen) begin
          lead++;
        end else begin
          tail++;
          rel0 += (bus_released_o !== 1'b1);
          nsamp += (rb_sample_o !== 1'b1);
        end
        @(posedge clock_i);
      end
      if (mid) bus(1'b1, TIMING_ADDR, t);
    join
    @(posedge clock_i);
    `CHK("lead", rd ? int'(tm.ce_to_re) : 0, lead)
    `CHK("low", (rd ? int'(tm.rd_low) : int'(tm.wr_low)) + 1, low)
    `CHK("tail", tail_t(tm, rd) + 1, tail)
    `CHK("release", rd ? tail_t(tm, 1'b1) - (tm.busy_dly > hi_x(tm.rd_high,
      tm.rd_low) + tm.turnaround ? tm.busy_dly - hi_x(tm.rd_high, tm.rd_low)
      - tm.turnaround : 0) : 0, rel0)
    `CHK("busy_wait", int'(tm.busy_dly), nsamp)
    if (mid) tm = t & TIMING_WMASK;
  endtask
  // closing verdict
  task results;
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // watchdog far beyond the expected few thousand cycles
  initial begin
    #100000;
    n_mismatch++;
    results();
  end
  // main sequence
  initial begin
    void'($urandom(32'h213FC620));
    repeat (10) @(posedge clock_i);
    srst_i <= 1'b0;
    @(posedge clock_i);
    bus(1'b0, TIMING_ADDR, 32'h0);
    `CHK("timing_reset", TIMING_RST, q)
    bus(1'b1, 8'h10, 32'hFFFFFFFF);
    bus(1'b0, 8'h10, 32'h0);
    `CHK("unmapped", 32'h0, q)
    bus(1'b0, CMD_ADDR, 32'h0);
    `CHK("cmd_read", 32'h0, q)
    // corners first: all zero, all max, high below low, then random
    for (int k = 0; k < 24; k++) begin
      nt = (k == 0) ? 32'h0 : (k == 1) ? 32'hFFFFFFFF
         : (k == 2) ? 32'h00000F0F : $urandom;
      bus(1'b1, TIMING_ADDR, nt);
      bus(1'b0, TIMING_ADDR, 32'h0);
      `CHK("timing", nt & TIMING_WMASK, q)
      tm = nt & TIMING_WMASK;
      // when k[1] is set, retime during the cycle, then check the next one
      flash_cycle(k[0], k[1], $urandom);
      if (k[1]) flash_cycle(k[0], 1'b0, 32'h0);
    end
    // busy delay 20, flash answers busy only when enabled
    for (int b = 1; b >= 0; b--) begin
      busy_en <= b[0];
      tm = 32'h00A00000;
      bus(1'b1, TIMING_ADDR, tm);
      flash_cycle(1'b1, 1'b0, 32'h0);
      bus(1'b0, STATUS_ADDR, 32'h0);
      `CHK("rb_seen", b[0], q[ST_RB_LOW_BIT])
      repeat (50) @(posedge clock_i);
    end
    // enable low mid-strobe: read wins, strobe and bus stay frozen
    bus(1'b1, TIMING_ADDR, 32'h0000_0300);
    bus(1'b1, CMD_ADDR, 32'h3);
    repeat (2) @(posedge clock_i);
    ce_i <= 1'b0;
    repeat (6) @(posedge clock_i);
    #1;
    `CHK("frozen_re", 1'b0, strobe_o.re_n)
    `CHK("frozen_we", 1'b1, strobe_o.we_n)
    `CHK("frozen_ready", 1'b0, hreadyout_o)
    @(posedge clock_i);
    ce_i <= 1'b1;
    repeat (6) @(posedge clock_i);
    `CHK("resumed_idle", 1'b1, strobe_o.ce_n)
    results();
  end
endmodule
